// *** inc/crm_consts.vh ***
/*
 Constants for the return / rotate / multiply-accumulate / subtract execution unit.
 Assumes inclusion by the unit's design file, its checker and its bench.
*/
`ifndef CRM_CONSTS_VH
`define CRM_CONSTS_VH

// Operation codes on op_code
`define CRM_OP_NONE      4'h0
`define CRM_OP_IRET      4'h1
`define CRM_OP_SRET      4'h2
`define CRM_OP_MAC       4'h3
`define CRM_OP_ROTATE_LEFT_THROUGH_CARRY_OP      4'h4
`define CRM_OP_ROTATE_RIGHT_THROUGH_CARRY_OP      4'h5
`define CRM_OP_ROT       4'h6
`define CRM_OP_SBB       4'h7
`define CRM_OP_SBRANCH   4'h8

// Flag register bit positions
`define CRM_FLG_C        0
`define CRM_FLG_D        1
`define CRM_FLG_Z        2
`define CRM_FLG_S        3
`define CRM_FLG_B        4
`define CRM_FLG_O        5
`define CRM_FLG_I        6
`define CRM_FLG_U        7

// Stack and address steps
`define CRM_STEP_WORD    16'h0002
`define CRM_STEP_BYTE    16'h0001

// Rotate count limits
`define CRM_ROT_MAX_B    5'h08
`define CRM_ROT_MAX_W    5'h10

// Subtract-then-branch immediate range and branch displacement range
`define CRM_SBI_MIN      (-7)
`define CRM_SBI_MAX      8
`define CRM_DISP_MIN     (-126)
`define CRM_DISP_MAX     129

// Reset values
`define CRM_RST_SP       16'h0000
`define CRM_RST_FLG      16'h0000
`define CRM_RST_PC       20'h00000

`endif

// *** src/crm_exec_unit.v ***
/*
 Execution unit for returns, repeated multiply-accumulate, carry rotates, multi-bit rotate,
 subtract with borrow and subtract-then-branch of a 16-bit CPU core.
 Assumes the decoder presents one operation with op_start, and memory answers a read within
 the cycle in which mem_rd stands (data on mem_rdata before the next edge).
*/
// The strobed register port and the register addresses were chosen for this implementation.
// What this block does
// - Interrupt return pops PC low word, SP+2, then PC high and flags, SP+2
// - Subroutine return pops PC low word, SP+2, then PC high byte, SP+1
// - Multiply-accumulate adds memory products, steps both addresses, decrements count to zero
// - Signed operands; 32-bit pair for word, 16-bit low register for byte
// - Accumulator overflow sets overflow flag and stops the loop
// - Overflow flag tracks signed 32 or 16-bit limits; other flags kept
// - On normal completion address registers point past the last operand read
// - Interrupts accepted only after an addition and count decrement
// - Left carry rotate: old carry into LSB, MSB out to carry
// - Right carry rotate: old carry into MSB, LSB out to carry
// - Carry rotates set sign from MSB, zero from result, carry from shifted bit
// - Multi-bit rotate by count magnitude, left if positive, right if negative
// - Bits leaving one end re-enter the other and copy into carry
// - Immediate count -8..-1 or 1..8; byte register count -8..8; zero does nothing
// - Word register count -16..16; zero does nothing; out of range undefined
// - Nonzero rotate sets sign, zero, and carry from last bit out
// - Subtract with borrow: dest minus src minus inverted carry
// - Byte size with address register dest: zero-extend source, 16-bit subtract
// - Borrow subtract sets overflow, sign, zero, and carry when no borrow
// - Subtract-then-branch stores difference, branches if nonzero, flags untouched
// - Branch immediate -7..+8; target -126..+129 from instruction start
// - Subtract and add branch share opcode; sign of immediate distinguishes them
`timescale 1ns/10ps
`include "crm_consts.vh"

module crm_exec_unit
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // Operation request from decoder
    input  wire        op_start,
    input  wire [3:0]  op_code,
    input  wire        op_word,
    input  wire        op_src_imm,
    input  wire        op_dst_areg,
    input  wire        op_src_areg,
    input  wire [15:0] op_src,
    input  wire [15:0] op_dst,
    input  wire [7:0]  op_imm4_enc,
    input  wire [7:0]  op_disp,
    input  wire [19:0] op_pc,
    input  wire        irq_pending,
    // Architectural registers loaded by core
    input  wire        reg_load,
    input  wire [15:0] ld_sp,
    input  wire [15:0] ld_flg,
    input  wire [31:0] ld_acc,
    input  wire [15:0] ld_a0,
    input  wire [15:0] ld_a1,
    input  wire [15:0] ld_cnt,
    // Memory read port
    output reg         mem_rd,
    output reg  [15:0] mem_addr,
    output reg         mem_word,
    input  wire [15:0] mem_rdata,
    // Results
    output reg         op_done,
    output reg         op_invalid,
    output reg         irq_accept,
    output reg  [15:0] res_dst,
    output reg         res_dst_we,
    output reg         branch_take,
    output reg  [19:0] pc_q,
    output reg  [15:0] sp_q,
    output reg  [15:0] flg_q,
    output reg  [31:0] acc_q,
    output reg  [15:0] a0_q,
    output reg  [15:0] a1_q,
    output reg  [15:0] cnt_q
);

    localparam [7:0] ST_IDLE = 8'h01;
    localparam [7:0] ST_POP1 = 8'h02;
    localparam [7:0] ST_POP2 = 8'h04;
    localparam [7:0] ST_POPW = 8'h08;
    localparam [7:0] ST_RDA  = 8'h10;
    localparam [7:0] ST_RDB  = 8'h20;
    localparam [7:0] ST_ACC  = 8'h40;
    localparam [7:0] ST_GAP  = 8'h80;

    reg [7:0]  st_q;
    reg [15:0] opa_q;
    reg        word_q;
    reg        iret_q;

    // Width-aware helpers
    function [15:0] fit;
        input [15:0] v;
        input        w;
        begin
            fit = w ? v : {8'h00, v[7:0]};
        end
    endfunction

    function msb_of;
        input [15:0] v;
        input        w;
        begin
            msb_of = w ? v[15] : v[7];
        end
    endfunction

    // Rotate left by n within 8 or 16 bits
    function [15:0] rotl;
        input [15:0] v;
        input [4:0]  n;
        input        w;
        reg   [31:0] d;
        reg   [15:0] b;
        begin
            d = 32'h0;
            b = 16'h0;
            if (w)
            begin
                d = {v, v} << n;
                rotl = d[31:16];
            end
            else
            begin
                b = {v[7:0], v[7:0]} << n[3:0];
                rotl = {8'h00, b[15:8]};
            end
        end
    endfunction

    // Combinational datapath for single-cycle operations
    reg [15:0] dv;
    reg [15:0] sv;
    reg [15:0] r;
    reg [16:0] diff;
    reg        c_new;
    reg        v_new;
    reg        rw;
    reg        rot_zero;
    reg [4:0]  mag;
    reg        rot_bad;
    reg        sub_neg;
    reg [15:0] sub_imm;
    reg [19:0] tgt;
    always @*
    begin
        rw = op_word;
        dv = fit(op_dst, rw);
        sv = fit(op_src, rw);
        r = 16'h0;
        diff = 17'h0;
        c_new = flg_q[`CRM_FLG_C];
        v_new = 1'b0;
        rot_zero = 1'b0;
        mag = 5'h0;
        rot_bad = 1'b0;
        sub_neg = op_imm4_enc[7];
        sub_imm = {{8{op_imm4_enc[7]}}, op_imm4_enc};
        tgt = op_pc + {{12{op_disp[7]}}, op_disp};
        case (op_code)
            `CRM_OP_ROTATE_LEFT_THROUGH_CARRY_OP:
            begin
                r = fit({dv[14:0], flg_q[`CRM_FLG_C]}, rw);
                c_new = msb_of(dv, rw);
            end
            `CRM_OP_ROTATE_RIGHT_THROUGH_CARRY_OP:
            begin
                r = rw ? {flg_q[`CRM_FLG_C], dv[15:1]}
                       : {8'h00, flg_q[`CRM_FLG_C], dv[7:1]};
                c_new = dv[0];
            end
            `CRM_OP_ROT:
            begin
                mag = op_src[4:0];
                if (rw ? op_src[15] : op_src[7])
                    mag = rw ? (5'h0 - op_src[4:0]) : (5'h0 - op_src[4:0]);
                rot_zero = (fit(op_src, rw) == 16'h0);
                rot_bad = op_src_imm ? (rot_zero || mag > `CRM_ROT_MAX_B) : 1'b0;
                if (rw ? op_src[15] : op_src[7])
                    r = rotl(dv, rw ? (5'h10 - mag) : (5'h08 - mag), rw);
                else
                    r = rotl(dv, mag, rw);
                c_new = (rw ? op_src[15] : op_src[7]) ? msb_of(r, rw) : r[0];
            end
            `CRM_OP_SBB:
            begin
                if (op_dst_areg && !rw)
                begin
                    dv = op_dst;
                    sv = {8'h00, op_src[7:0]};
                    diff = {1'b0, dv} - {1'b0, sv} - {16'h0, ~flg_q[`CRM_FLG_C]};
                    r = diff[15:0];
                    v_new = (dv[15] ^ sv[15]) & (dv[15] ^ r[15]);
                end
                else
                begin
                    if (op_src_areg && !rw)
                        sv = {8'h00, op_src[7:0]};
                    diff = {1'b0, dv} - {1'b0, sv} - {16'h0, ~flg_q[`CRM_FLG_C]};
                    r = fit(diff[15:0], rw);
                    v_new = (msb_of(dv, rw) ^ msb_of(sv, rw))
                          & (msb_of(dv, rw) ^ msb_of(r, rw));
                end
                c_new = rw || (op_dst_areg) ? ~diff[16] : ~diff[8];
            end
            `CRM_OP_SBRANCH:
            begin
                r = fit(dv - sub_imm, rw);
            end
            default:
            begin
                r = 16'h0;
            end
        endcase
    end

    // Accumulate step on the two fetched operands
    reg signed [31:0] prod;
    reg signed [32:0] sum;
    reg        ovf;
    always @*
    begin
        prod = word_q ? $signed(opa_q) * $signed(mem_rdata)
                      : $signed({{8{opa_q[7]}}, opa_q[7:0]}) * $signed({{8{mem_rdata[7]}},
                        mem_rdata[7:0]});
        if (word_q)
            sum = $signed({acc_q[31], acc_q}) + $signed({prod[31], prod});
        else
            sum = $signed({{17{acc_q[15]}}, acc_q[15:0]}) + $signed({prod[31], prod});
        ovf = word_q ? (sum[32] != sum[31])
                     : (sum[32:15] != {18{sum[15]}});
    end

    wire [15:0] step = word_q ? `CRM_STEP_WORD : `CRM_STEP_BYTE;

    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            st_q <= ST_IDLE;
            opa_q <= 16'h0;
            word_q <= 1'b0;
            iret_q <= 1'b0;
            mem_rd <= 1'b0;
            mem_addr <= 16'h0;
            mem_word <= 1'b0;
            op_done <= 1'b0;
            op_invalid <= 1'b0;
            irq_accept <= 1'b0;
            res_dst <= 16'h0;
            res_dst_we <= 1'b0;
            branch_take <= 1'b0;
            pc_q <= `CRM_RST_PC;
            sp_q <= `CRM_RST_SP;
            flg_q <= `CRM_RST_FLG;
            acc_q <= 32'h0;
            a0_q <= 16'h0;
            a1_q <= 16'h0;
            cnt_q <= 16'h0;
        end
        else
        begin
            mem_rd <= 1'b0;
            op_done <= 1'b0;
            op_invalid <= 1'b0;
            irq_accept <= 1'b0;
            res_dst_we <= 1'b0;
            branch_take <= 1'b0;
            case (st_q)
                ST_IDLE:
                begin
                    if (reg_load)
                    begin
                        sp_q <= ld_sp;
                        flg_q <= ld_flg;
                        acc_q <= ld_acc;
                        a0_q <= ld_a0;
                        a1_q <= ld_a1;
                        cnt_q <= ld_cnt;
                    end
                    else if (op_start)
                    begin
                        word_q <= op_word;
                        case (op_code)
                            `CRM_OP_IRET, `CRM_OP_SRET:
                            begin
                                iret_q <= (op_code == `CRM_OP_IRET);
                                mem_rd <= 1'b1;
                                mem_word <= 1'b1;
                                mem_addr <= sp_q;
                                sp_q <= sp_q + `CRM_STEP_WORD;
                                st_q <= ST_POP1;
                            end
                            `CRM_OP_MAC:
                            begin
                                if (cnt_q == 16'h0)
                                    op_done <= 1'b1;
                                else
                                begin
                                    mem_rd <= 1'b1;
                                    mem_word <= op_word;
                                    mem_addr <= a0_q;
                                    st_q <= ST_RDA;
                                end
                            end
                            `CRM_OP_ROTATE_LEFT_THROUGH_CARRY_OP, `CRM_OP_ROTATE_RIGHT_THROUGH_CARRY_OP:
                            begin
                                res_dst <= r;
                                res_dst_we <= 1'b1;
                                flg_q[`CRM_FLG_C] <= c_new;
                                flg_q[`CRM_FLG_S] <= msb_of(r, op_word);
                                flg_q[`CRM_FLG_Z] <= (r == 16'h0);
                                op_done <= 1'b1;
                            end
                            `CRM_OP_ROT:
                            begin
                                op_done <= 1'b1;
                                if (rot_bad)
                                    op_invalid <= 1'b1;
                                else if (!rot_zero)
                                begin
                                    res_dst <= r;
                                    res_dst_we <= 1'b1;
                                    flg_q[`CRM_FLG_C] <= c_new;
                                    flg_q[`CRM_FLG_S] <= msb_of(r, op_word);
                                    flg_q[`CRM_FLG_Z] <= (fit(r, op_word) == 16'h0);
                                end
                            end
                            `CRM_OP_SBB:
                            begin
                                res_dst <= r;
                                res_dst_we <= 1'b1;
                                flg_q[`CRM_FLG_O] <= v_new;
                                flg_q[`CRM_FLG_C] <= c_new;
                                flg_q[`CRM_FLG_S] <= (op_dst_areg && !op_word) ? r[15]
                                                                : msb_of(r, op_word);
                                flg_q[`CRM_FLG_Z] <= (r == 16'h0);
                                op_done <= 1'b1;
                            end
                            `CRM_OP_SBRANCH:
                            begin
                                op_done <= 1'b1;
                                if (sub_neg ? ($signed(sub_imm) < `CRM_SBI_MIN)
                                            : ($signed(sub_imm) > `CRM_SBI_MAX))
                                    op_invalid <= 1'b1;
                                else
                                begin
                                    res_dst <= r;
                                    res_dst_we <= 1'b1;
                                    if (r != 16'h0)
                                    begin
                                        branch_take <= 1'b1;
                                        pc_q <= tgt;
                                    end
                                end
                            end
                            default:
                            begin
                                op_invalid <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_POP1:
                begin
                    pc_q[15:0] <= mem_rdata;
                    mem_rd <= 1'b1;
                    mem_addr <= sp_q;
                    mem_word <= iret_q;
                    sp_q <= sp_q + (iret_q ? `CRM_STEP_WORD : `CRM_STEP_BYTE);
                    st_q <= ST_POP2;
                end
                ST_POP2:
                begin
                    if (iret_q)
                    begin
                        pc_q[19:16] <= mem_rdata[15:12];
                        flg_q <= {4'h0, mem_rdata[11:0]};
                    end
                    else
                        pc_q[19:16] <= mem_rdata[3:0];
                    op_done <= 1'b1;
                    st_q <= ST_IDLE;
                end
                ST_RDA:
                begin
                    opa_q <= mem_rdata;
                    mem_rd <= 1'b1;
                    mem_addr <= a1_q;
                    st_q <= ST_RDB;
                end
                ST_RDB:
                begin
                    a0_q <= a0_q + step;
                    a1_q <= a1_q + step;
                    if (word_q)
                        acc_q <= sum[31:0];
                    else
                        acc_q[15:0] <= sum[15:0];
                    flg_q[`CRM_FLG_O] <= ovf;
                    cnt_q <= cnt_q - 16'h0001;
                    st_q <= ST_ACC;
                end
                ST_ACC:
                begin
                    if (flg_q[`CRM_FLG_O] || cnt_q == 16'h0)
                    begin
                        op_done <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                    else if (irq_pending)
                    begin
                        irq_accept <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                    else
                    begin
                        mem_rd <= 1'b1;
                        mem_addr <= a0_q;
                        st_q <= ST_RDA;
                    end
                end
                default:
                begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// *** verification/crm_exec_unit_assertions.sv ***
/*
 Concurrent checks on the ports of crm_exec_unit, bound after the checker module.
 Assumes the constants header on the include path and a single clock with sync low reset.
*/
`timescale 1ns/10ps
`include "crm_consts.vh"

module crm_exec_unit_checker
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // Request side
    input wire logic        op_start,
    input wire logic [3:0]  op_code,
    input wire logic        op_word,
    input wire logic        op_src_imm,
    input wire logic [15:0] op_src,
    input wire logic [15:0] op_dst,
    // Result side
    input wire logic        mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic        op_done,
    input wire logic        res_dst_we,
    input wire logic [15:0] res_dst,
    input wire logic        branch_take,
    input wire logic [15:0] sp_q,
    input wire logic [15:0] flg_q,
    input wire logic [31:0] acc_q,
    input wire logic [15:0] cnt_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    wire cnt_q_nz = (cnt_q != 16'h0000);

    iret_pops_a: assert property (op_start && op_code == `CRM_OP_IRET
        |=> mem_rd && mem_addr == $past(sp_q)
        ##1 mem_rd && mem_addr == $past(sp_q, 2) + 16'h0002
        ##1 op_done && sp_q == $past(sp_q, 3) + 16'h0004)
        else $error("interrupt return pops wrong");
    sret_pops_a: assert property (op_start && op_code == `CRM_OP_SRET
        |=> mem_rd ##1 mem_rd
        ##1 op_done && sp_q == $past(sp_q, 3) + 16'h0003 && flg_q == $past(flg_q, 3))
        else $error("subroutine return pops wrong");
    mac_reads_a: assert property (op_start && op_code == `CRM_OP_MAC && cnt_q_nz
        |=> mem_rd ##1 mem_rd) else $error("step reads missing");
    mac_idle_a: assert property (op_start && op_code == `CRM_OP_MAC && !cnt_q_nz
        |=> op_done && !mem_rd && $stable(acc_q) ##1 !mem_rd && $stable(acc_q))
        else $error("zero count did work");
    mac_flags_a: assert property (op_start && op_code == `CRM_OP_MAC
        |=> $stable({flg_q[7:6], flg_q[4:0]}) [*3]) else $error("step touched other flags");
    rotate_left_through_carry_op_bits_a: assert property (op_start && op_code == `CRM_OP_ROTATE_LEFT_THROUGH_CARRY_OP
        |=> op_done && res_dst_we && res_dst[0] == $past(flg_q[0])
        && flg_q[0] == ($past(op_word) ? $past(op_dst[15]) : $past(op_dst[7])))
        else $error("left carry rotate wrong");
    rotate_right_through_carry_op_bits_a: assert property (op_start && op_code == `CRM_OP_ROTATE_RIGHT_THROUGH_CARRY_OP
        |=> op_done && flg_q[0] == $past(op_dst[0])
        && ($past(op_word) ? res_dst[15] : res_dst[7]) == $past(flg_q[0]))
        else $error("right carry rotate wrong");
    rot_zero_a: assert property (op_start && op_code == `CRM_OP_ROT && !op_src_imm
        && op_src == 16'h0000 |=> $stable(flg_q)) else $error("zero rotate changed flags");
    sbb_word_a: assert property (op_start && op_code == `CRM_OP_SBB && op_word
        |=> res_dst == $past(op_dst) - $past(op_src) - {15'h0000, ~$past(flg_q[0])})
        else $error("borrow subtract wrong");
    sbr_take_a: assert property (op_start && op_code == `CRM_OP_SBRANCH
        |=> op_done && flg_q == $past(flg_q) && branch_take == ($past(op_word)
        ? res_dst != 16'h0000 : res_dst[7:0] != 8'h00)) else $error("branch decision wrong");
endmodule

bind crm_exec_unit crm_exec_unit_checker i_crm_exec_unit_checker (.clk_sys, .rstn, .op_start,
    .op_code, .op_word, .op_src_imm, .op_src, .op_dst, .mem_rd, .mem_addr, .op_done, .res_dst_we,
    .res_dst, .branch_take, .sp_q, .flg_q, .acc_q, .cnt_q);

// *** verification/crm_exec_unit_bench.sv ***
/*
 Self-checking bench for crm_exec_unit: returns, multiply-accumulate, rotates, subtracts.
 Assumes the constants header on the include path; the bench acts as decoder and memory.
*/
`timescale 1ns/10ps
`include "crm_consts.vh"

module crm_exec_unit_bench;
    logic clk_sys = 1'b0, rstn = 1'b0, op_start = 1'b0, op_word = 1'b0, op_src_imm = 1'b0;
    logic op_dst_areg = 1'b0, op_src_areg = 1'b0, irq_pending = 1'b0, reg_load = 1'b0;
    logic [3:0] op_code = 4'h0;
    logic [15:0] op_src = 16'h0, op_dst = 16'h0, ld_sp = 16'h0, ld_flg = 16'h0, ld_a0 = 16'h0;
    logic [15:0] ld_a1 = 16'h0, ld_cnt = 16'h0, mem_rdata, rs;
    logic [7:0] op_imm4_enc = 8'h03, op_disp = 8'hF0;
    logic [19:0] op_pc = 20'h01000;
    logic [31:0] ld_acc = 32'h0;
    wire mem_rd, mem_word, op_done, op_invalid, irq_accept, res_dst_we, branch_take;
    wire [15:0] mem_addr, res_dst, sp_q, flg_q, a0_q, a1_q, cnt_q;
    wire [19:0] pc_q;
    wire [31:0] acc_q;
    wire [7:0] ma = mem_addr[7:0];
    logic [7:0] m [256] = '{default: 8'h00};
    logic we, tk, inv, irq_a;
    int err_total = 0, total_checks = 0;
    logic [31:0] mi [14] = '{32'h0010_1234, 32'h0012_50A5, 32'h0020_BEEF, 32'h0022_0007,
        32'h0040_0003, 32'h0042_FFFE, 32'h0050_FFFC, 32'h0052_0007, 32'h0060_0281,
        32'h0062_0001, 32'h0070_FD02, 32'h0072_0005, 32'h0080_007F, 32'h0090_007F};

    crm_exec_unit i_crm_exec_unit (.clk_sys, .rstn, .op_start, .op_code, .op_word, .op_src_imm,
        .op_dst_areg, .op_src_areg, .op_src, .op_dst, .op_imm4_enc, .op_disp, .op_pc,
        .irq_pending, .reg_load, .ld_sp, .ld_flg, .ld_acc, .ld_a0, .ld_a1, .ld_cnt, .mem_rd,
        .mem_addr, .mem_word, .mem_rdata, .op_done, .op_invalid, .irq_accept, .res_dst,
        .res_dst_we, .branch_take, .pc_q, .sp_q, .flg_q, .acc_q, .a0_q, .a1_q, .cnt_q);

    always #12.5 clk_sys = ~clk_sys;

    // Memory answers while the read strobe stands, otherwise shows the inverse
    always @*
        if (mem_rd === 1'b1)
            mem_rdata = mem_word ? {m[ma + 8'h01], m[ma]} : {8'h5A, m[ma]};
        else
            mem_rdata = ~{m[ma + 8'h01], m[ma]};

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic ld(input logic [15:0] sp, fl, input logic [31:0] ac,
                      input logic [15:0] x0, x1, ct);
        ld_sp <= sp;
        ld_flg <= fl;
        ld_acc <= ac;
        ld_a0 <= x0;
        ld_a1 <= x1;
        ld_cnt <= ct;
        reg_load <= 1'b1;
        @(posedge clk_sys);
        reg_load <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic go(input logic [3:0] c, input logic w, input logic [15:0] d, s,
                      input logic im);
        int n;
        n = 0;
        op_code <= c;
        op_word <= w;
        op_dst <= d;
        op_src <= s;
        op_src_imm <= im;
        op_start <= 1'b1;
        @(posedge clk_sys);
        op_start <= 1'b0;
        #1;
        while (!(op_done === 1'b1 || op_invalid === 1'b1 || irq_accept === 1'b1) && n < 300)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 300)
        begin
            err_total++;
            conclude();
        end
        we = res_dst_we;
        rs = res_dst;
        tk = branch_take;
        inv = op_invalid;
        irq_a = irq_accept;
        @(posedge clk_sys);
    endtask

    // Single-cycle operation from a clean flag state holding only the carry
    task automatic al(input logic [3:0] c, input logic w, im, ci,
                      input logic [15:0] d, s, r, input logic [3:0] f);
        logic [15:0] e;
        ld(16'h0000, {15'h0000, ci}, 32'h0, 16'h0000, 16'h0000, 16'h0000);
        go(c, w, d, s, im);
        e = we ? rs : d;
        chk((w || op_dst_areg) ? e : {8'h00, e[7:0]}, r);
        chk({flg_q[5], flg_q[3], flg_q[2], flg_q[0]}, f);
    endtask

    initial
    begin
        foreach (mi[i])
        begin
            m[mi[i][23:16]] = mi[i][7:0];
            m[mi[i][23:16] + 8'h01] = mi[i][15:8];
        end
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk({sp_q, flg_q}, 32'h0);
        ld(16'h0010, 16'h0000, 32'h0, 16'h0000, 16'h0000, 16'h0000);
        go(`CRM_OP_IRET, 1'b1, 16'h0, 16'h0, 1'b0);
        chk({pc_q, flg_q[7:0]}, 32'h051234A5);
        chk(sp_q, 16'h0014);
        ld(16'h0020, 16'h000F, 32'h0, 16'h0000, 16'h0000, 16'h0000);
        go(`CRM_OP_SRET, 1'b1, 16'h0, 16'h0, 1'b0);
        chk({pc_q, flg_q[7:0]}, 32'h07BEEF0F);
        chk(sp_q, 16'h0023);
        ld(16'h0000, 16'h0000, 32'h5, 16'h0040, 16'h0050, 16'h0002);
        go(`CRM_OP_MAC, 1'b1, 16'h0, 16'h0, 1'b0);
        chk(acc_q, 32'hFFFFFFEB);
        chk({a0_q, a1_q}, 32'h00440054);
        chk({cnt_q, flg_q}, 32'h0);
        ld(16'h0000, 16'h000D, 32'hAAAA0010, 16'h0060, 16'h0070, 16'h0003);
        go(`CRM_OP_MAC, 1'b0, 16'h0, 16'h0, 1'b0);
        chk(acc_q, 32'hAAAAFF11);
        chk({a0_q, a1_q}, 32'h00630073);
        chk(flg_q, 16'h000D);
        ld(16'h0000, 16'h0000, 32'h00007F00, 16'h0080, 16'h0090, 16'h0003);
        go(`CRM_OP_MAC, 1'b0, 16'h0, 16'h0, 1'b0);
        chk(flg_q[5], 1'b1);
        ld(16'h0000, 16'h0000, 32'h12345678, 16'h0040, 16'h0050, 16'h0000);
        go(`CRM_OP_MAC, 1'b1, 16'h0, 16'h0, 1'b0);
        chk({acc_q, a0_q}, {32'h12345678, 16'h0040});
        irq_pending <= 1'b1;
        ld(16'h0000, 16'h0000, 32'h0, 16'h0040, 16'h0050, 16'h0002);
        go(`CRM_OP_MAC, 1'b1, 16'h0, 16'h0, 1'b0);
        chk({irq_a, cnt_q, acc_q}, {1'b1, 16'h0001, 32'hFFFFFFF4});
        irq_pending <= 1'b0;
        go(`CRM_OP_MAC, 1'b1, 16'h0, 16'h0, 1'b0);
        chk({acc_q, a0_q}, {32'hFFFFFFE6, 16'h0044});
        al(`CRM_OP_ROTATE_LEFT_THROUGH_CARRY_OP, 1'b0, 1'b0, 1'b0, 16'h0081, 16'h0, 16'h0002, 4'b0001);
        al(`CRM_OP_ROTATE_LEFT_THROUGH_CARRY_OP, 1'b1, 1'b0, 1'b1, 16'h4000, 16'h0, 16'h8001, 4'b0100);
        al(`CRM_OP_ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b1, 1'b0, 1'b0, 16'h0001, 16'h0, 16'h0000, 4'b0011);
        al(`CRM_OP_ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0, 16'h0080, 4'b0100);
        al(`CRM_OP_ROT, 1'b0, 1'b1, 1'b0, 16'h0081, 16'h1, 16'h0003, 4'b0001);
        al(`CRM_OP_ROT, 1'b1, 1'b1, 1'b0, 16'h0001, 16'hFFFD, 16'h2000, 4'b0000);
        al(`CRM_OP_ROT, 1'b1, 1'b0, 1'b1, 16'h1234, 16'h0010, 16'h1234, 4'b0000);
        al(`CRM_OP_ROT, 1'b0, 1'b0, 1'b0, 16'h00A5, 16'h00F8, 16'h00A5, 4'b0101);
        al(`CRM_OP_ROT, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000, 4'b0001);
        go(`CRM_OP_ROT, 1'b0, 16'h0055, 16'h0000, 1'b1);
        chk(inv, 1'b1);
        al(`CRM_OP_SBB, 1'b1, 1'b0, 1'b1, 16'h8000, 16'h0001, 16'h7FFF, 4'b1001);
        al(`CRM_OP_SBB, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h00FF, 4'b0100);
        op_dst_areg <= 1'b1;
        al(`CRM_OP_SBB, 1'b0, 1'b0, 1'b1, 16'h0100, 16'h0001, 16'h00FF, 4'b0001);
        op_dst_areg <= 1'b0;
        op_src_areg <= 1'b1;
        al(`CRM_OP_SBB, 1'b0, 1'b0, 1'b1, 16'h0005, 16'h1203, 16'h0002, 4'b0001);
        op_src_areg <= 1'b0;
        al(`CRM_OP_SBRANCH, 1'b1, 1'b0, 1'b1, 16'h000A, 16'h0, 16'h0007, 4'b0001);
        chk({tk, pc_q}, {1'b1, 20'h00FF0});
        op_imm4_enc <= 8'h01;
        al(`CRM_OP_SBRANCH, 1'b1, 1'b0, 1'b1, 16'h0001, 16'h0, 16'h0000, 4'b0001);
        chk(tk, 1'b0);
        op_imm4_enc <= 8'hFD;
        al(`CRM_OP_SBRANCH, 1'b0, 1'b0, 1'b0, 16'h00FD, 16'h0, 16'h0000, 4'b0000);
        conclude();
    end
endmodule
